// ==== logic/scfg_defines.vh ====
`ifndef SCFG_DEFINES_VH
`define SCFG_DEFINES_VH
// frame layout
`define SCFG_FRAME_BITS 6'h20
`define SCFG_DATA_BITS 27
`define SCFG_ADDR_MASTER 4'h0
`define SCFG_ADDR_SIGMA_NUMERATOR_WORD 4'h1
`define SCFG_ADDR_MODU 4'h2
`define SCFG_ADDR_REFL 4'h3
`define SCFG_ADDR_LOCK 4'h4
// field positions
`define SCFG_SHADOW_BIT 26
`define SCFG_SLEEP_BIT 25
`define SCFG_OUT_OFF_BIT 24
`define SCFG_DIV_HI 23
`define SCFG_DIV_LO 21
`define SCFG_WORD_HI 20
`define SCFG_LEAK_X2_BIT 24
`define SCFG_LEAK_HI 23
`define SCFG_LEAK_LO 19
`define SCFG_LEAK_DIR_BIT 18
`define SCFG_DNSPLIT_BIT 17
`define SCFG_DLY_HI 16
`define SCFG_DLY_LO 15
`define SCFG_RPATH_HI 14
`define SCFG_RPATH_LO 13
`define SCFG_RDIV_HI 12
`define SCFG_PWR_HI 25
`define SCFG_PWR_LO 23
`define SCFG_EXTVCO_BIT 19
`define SCFG_FBMUX_BIT 14
`define SCFG_POL_BIT 10
`define SCFG_RTYPE_HI 9
`define SCFG_RTYPE_LO 8
`define SCFG_MUTE_BIT 7
`define SCFG_LDINV_BIT 6
`define SCFG_WIN_HI 5
`define SCFG_WIN_LO 3
`define SCFG_CNT_HI 2
`define SCFG_MDEL_HI 20
`define SCFG_MDEL_LO 19
// reset values
`define SCFG_RST_WORD 27'h0000000
// timing: window step in ns, clock period in ns
`define SCFG_WIN_STEP_NS 8'h02
`define SCFG_CLK_NS 5
`endif

// ==== logic/scfg_lock_detect.v ====
`timescale 1ns/1ps
`include "scfg_defines.vh"
// lock detector: counts consecutive in-window comparisons
module scfg_lock_detect (
	input wire clk,
	input wire rstn,
	input wire cmp_valid,
	input wire [7:0] phase_err_ns,
	input wire [2:0] lock_window_width,
	input wire [2:0] lock_comparison_count,
	output reg locked_ff
);
	reg [12:0] run_ff;
	reg [12:0] need;
	wire [7:0] window_ns;
	// window = (code+1)*2 ns
	assign window_ns = ({5'h00, lock_window_width} + 8'h01) * `SCFG_WIN_STEP_NS;
	always @* begin
		case (lock_comparison_count)
			3'h0: need = 13'h0004;
			3'h1: need = 13'h0008;
			3'h2: need = 13'h0010;
			3'h3: need = 13'h0040;
			3'h4: need = 13'h0100;
			3'h5: need = 13'h0400;
			3'h6: need = 13'h0800;
			default: need = 13'h1000;
		endcase
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run_ff <= 13'h0000;
			locked_ff <= 1'b0;
		end else if (cmp_valid) begin
			if (phase_err_ns > window_ns) begin
				run_ff <= 13'h0000;
				locked_ff <= 1'b0;
			end else begin
				if (run_ff < need)
					run_ff <= run_ff + 13'h0001;
				if (run_ff + 13'h0001 >= need)
					locked_ff <= 1'b1;
			end
		end
	end
endmodule

// ==== logic/scfg_regs.v ====
`timescale 1ns/1ps
`include "scfg_defines.vh"
module scfg_regs (
	input wire clk,
	input wire rstn,
	input wire sclk,
	input wire sdata,
	input wire latch_en,
	input wire cmp_valid,
	input wire [7:0] phase_err_ns,
	output reg first_output_off_ff,
	output reg second_output_off_ff,
	output reg [2:0] first_output_divide_select_ff,
	output reg [2:0] second_output_divide_select_ff,
	output reg [20:0] sigma_numerator_word_ff,
	output reg [20:0] fraction_denominator_ff,
	output reg chip_sleep_ff,
	output reg leakage_step_double_ff,
	output reg [4:0] pump_bleed_code_ff,
	output reg [9:0] leak_current_ua_ff,
	output reg pump_bleed_direction_ff,
	output reg down_split_enable_ff,
	output reg [1:0] down_split_level_ff,
	output reg [1:0] detector_delay_path_ff,
	output reg [1:0] ref_path_select_ff,
	output reg [12:0] ref_divider_ff,
	output reg [2:0] output_level_code_ff,
	output reg external_oscillator_select_ff,
	output reg internal_osc_on_ff,
	output reg feedback_divided_ff,
	output reg detector_polarity_ff,
	output reg [1:0] reference_input_type_ff,
	output reg first_output_on_ff,
	output reg second_output_on_ff,
	output reg lock_indicator_ff,
	output reg calib_start_ff
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	reg [1:0] sclk_sync_ff;
	reg [1:0] sdat_sync_ff;
	reg [1:0] le_sync_ff;
	reg sclk_prev_ff;
	reg le_prev_ff;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sclk_sync_ff <= 2'h0;
			sdat_sync_ff <= 2'h0;
			// latch idles high, so no false rise right after reset
			le_sync_ff <= 2'h3;
			sclk_prev_ff <= 1'b0;
			le_prev_ff <= 1'b1;
		end else begin
			sclk_sync_ff <= {sclk_sync_ff[0], sclk};
			sdat_sync_ff <= {sdat_sync_ff[0], sdata};
			le_sync_ff <= {le_sync_ff[0], latch_en};
			sclk_prev_ff <= sclk_sync_ff[1];
			le_prev_ff <= le_sync_ff[1];
		end
	end
	// data and clock share sync depth, so sampled data matches the edge
	wire sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
	wire le_rise = le_sync_ff[1] & ~le_prev_ff;
	// ****************************************
	// serial frame shifter
	// ****************************************
	reg [31:0] shift_ff;
	reg [5:0] bit_cnt_ff;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			shift_ff <= 32'h00000000;
			bit_cnt_ff <= 6'h00;
		end else if (le_rise) begin
			bit_cnt_ff <= 6'h00;
		end else if (sclk_rise && !le_sync_ff[1]) begin
			shift_ff <= {shift_ff[30:0], sdat_sync_ff[1]};
			if (bit_cnt_ff != 6'h3f)
				bit_cnt_ff <= bit_cnt_ff + 6'h01;
		end
	end
	// exactly 32 bits, write bit 0, then address, then data
	wire frame_ok = le_rise && (bit_cnt_ff == `SCFG_FRAME_BITS) && !shift_ff[31];
	wire [3:0] addr = shift_ff[30:27];
	wire [26:0] data = shift_ff[26:0];
	wire hold = data[`SCFG_SHADOW_BIT];
	wire wr_master = frame_ok && (addr == `SCFG_ADDR_MASTER);
	// ****************************************
	// registers and shadows
	// ****************************************
	reg [26:0] lock_reg_ff;
	reg [1:0] master_dly_ff;
	// one driver per slot: each entry keeps its own state, packed onto a bus
	wire [80:0] act_bus;
	genvar gi;
	generate
		for (gi = 1; gi <= 3; gi = gi + 1) begin : g_buf
			reg [26:0] act_ff;
			reg [26:0] shd_ff;
			reg pend_ff;
			wire hit = frame_ok && ({28'h0000000, addr} == gi);
			always @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					act_ff <= `SCFG_RST_WORD;
					shd_ff <= `SCFG_RST_WORD;
					pend_ff <= 1'b0;
				end else if (hit && hold) begin
					shd_ff <= data;
					pend_ff <= 1'b1;
				end else if (hit) begin
					act_ff <= data;
					pend_ff <= 1'b0;
				end else if (wr_master && pend_ff) begin
					act_ff <= shd_ff;
					pend_ff <= 1'b0;
				end
			end
			assign act_bus[(gi - 1) * 27 +: 27] = act_ff;
		end
	endgenerate
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lock_reg_ff <= `SCFG_RST_WORD;
			master_dly_ff <= 2'h0;
		end else begin
			if (frame_ok && addr == `SCFG_ADDR_LOCK)
				lock_reg_ff <= data;
			// down split level lives in master delay field
			if (wr_master)
				master_dly_ff <= data[`SCFG_MDEL_HI:`SCFG_MDEL_LO];
		end
	end
	// ****************************************
	// lock detector
	// ****************************************
	wire locked;
	scfg_lock_detect u_lock (
		.clk(clk),
		.rstn(rstn),
		.cmp_valid(cmp_valid),
		.phase_err_ns(phase_err_ns),
		.lock_window_width(lock_reg_ff[`SCFG_WIN_HI:`SCFG_WIN_LO]),
		.lock_comparison_count(lock_reg_ff[`SCFG_CNT_HI:0]),
		.locked_ff(locked)
	);
	// ****************************************
	// decoded control outputs
	// ****************************************
	wire [26:0] r1 = act_bus[26:0];
	wire [26:0] r2 = act_bus[53:27];
	wire [26:0] r3 = act_bus[80:54];
	wire mute = lock_reg_ff[`SCFG_MUTE_BIT] && !locked;
	wire sleep = r3[`SCFG_SLEEP_BIT];
	wire [9:0] step = r3[`SCFG_LEAK_X2_BIT] ? 10'h014 : 10'h00a;
	wire [1:0] dly = r3[`SCFG_DLY_HI:`SCFG_DLY_LO];
	wire [1:0] rtype = lock_reg_ff[`SCFG_RTYPE_HI:`SCFG_RTYPE_LO];
	wire [2:0] div2 = r2[`SCFG_DIV_HI:`SCFG_DIV_LO];
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			first_output_off_ff <= 1'b0;
			second_output_off_ff <= 1'b0;
			first_output_divide_select_ff <= 3'h0;
			second_output_divide_select_ff <= 3'h0;
			sigma_numerator_word_ff <= 21'h000000;
			fraction_denominator_ff <= 21'h000000;
			chip_sleep_ff <= 1'b0;
			leakage_step_double_ff <= 1'b0;
			pump_bleed_code_ff <= 5'h00;
			leak_current_ua_ff <= 10'h000;
			pump_bleed_direction_ff <= 1'b0;
			down_split_enable_ff <= 1'b0;
			down_split_level_ff <= 2'h0;
			detector_delay_path_ff <= 2'h0;
			ref_path_select_ff <= 2'h0;
			ref_divider_ff <= 13'h0000;
			output_level_code_ff <= 3'h0;
			external_oscillator_select_ff <= 1'b0;
			internal_osc_on_ff <= 1'b0;
			feedback_divided_ff <= 1'b0;
			detector_polarity_ff <= 1'b0;
			reference_input_type_ff <= 2'h0;
			first_output_on_ff <= 1'b0;
			second_output_on_ff <= 1'b0;
			lock_indicator_ff <= 1'b0;
			calib_start_ff <= 1'b0;
		end else begin
			first_output_off_ff <= r1[`SCFG_OUT_OFF_BIT];
			second_output_off_ff <= r2[`SCFG_OUT_OFF_BIT];
			// reserved 111 holds direct
			first_output_divide_select_ff <= (r1[`SCFG_DIV_HI:`SCFG_DIV_LO] == 3'h7) ? 3'h0 :
				r1[`SCFG_DIV_HI:`SCFG_DIV_LO];
			// 111 follows first divider; invalid with first code 000 (direct), so forced direct; first code 111 leaves it 111
			second_output_divide_select_ff <= (div2 == 3'h7 && r1[`SCFG_DIV_HI:`SCFG_DIV_LO] == 3'h0) ? 3'h0 :
				div2;
			sigma_numerator_word_ff <= r1[`SCFG_WORD_HI:0];
			fraction_denominator_ff <= r2[`SCFG_WORD_HI:0];
			chip_sleep_ff <= sleep;
			leakage_step_double_ff <= r3[`SCFG_LEAK_X2_BIT];
			pump_bleed_code_ff <= r3[`SCFG_LEAK_HI:`SCFG_LEAK_LO];
			leak_current_ua_ff <= {5'h00, r3[`SCFG_LEAK_HI:`SCFG_LEAK_LO]} * step;
			pump_bleed_direction_ff <= r3[`SCFG_LEAK_DIR_BIT];
			down_split_enable_ff <= r3[`SCFG_DNSPLIT_BIT] && !sleep;
			down_split_level_ff <= r3[`SCFG_DNSPLIT_BIT] ? master_dly_ff : 2'h0;
			detector_delay_path_ff <= (dly == 2'h3) ? 2'h0 : dly;
			// doubling is not applicable with differential input
			ref_path_select_ff <= (r3[`SCFG_RPATH_HI:`SCFG_RPATH_LO] == 2'h1 && rtype == 2'h1) ? 2'h0 :
				r3[`SCFG_RPATH_HI:`SCFG_RPATH_LO];
			ref_divider_ff <= r3[`SCFG_RDIV_HI:0];
			output_level_code_ff <= lock_reg_ff[`SCFG_PWR_HI:`SCFG_PWR_LO];
			external_oscillator_select_ff <= lock_reg_ff[`SCFG_EXTVCO_BIT] && !sleep;
			internal_osc_on_ff <= !lock_reg_ff[`SCFG_EXTVCO_BIT] && !sleep;
			feedback_divided_ff <= lock_reg_ff[`SCFG_FBMUX_BIT];
			detector_polarity_ff <= lock_reg_ff[`SCFG_POL_BIT];
			reference_input_type_ff <= rtype;
			first_output_on_ff <= !r1[`SCFG_OUT_OFF_BIT] && !mute && !sleep;
			second_output_on_ff <= !r2[`SCFG_OUT_OFF_BIT] && !mute && !sleep;
			lock_indicator_ff <= locked ^ lock_reg_ff[`SCFG_LDINV_BIT];
			calib_start_ff <= wr_master;
		end
	end
endmodule

// ==== tb/scfg_host_model.sv ====
`timescale 1ns/1ps
module scfg_host_model (
	output logic sclk,
	output logic sdata,
	output logic latch_en
);
	// ****************
	// serial frames
	// ****************
	initial begin
		sclk = 1'b0;
		sdata = 1'b0;
		latch_en = 1'b1;
	end
	// short frames are sent only to see them refused
	task automatic send(input logic rd, input logic [3:0] addr, input logic [26:0] data, input int nbits);
		logic [31:0] frame;
		frame = {rd, addr, data};
		latch_en = 1'b0;
		for (int i = 31; i >= 32 - nbits; i--) begin
			sdata = frame[i];
			#80 sclk = 1'b1;
			#80 sclk = 1'b0;
		end
		sdata = ~sdata;
		#80 latch_en = 1'b1;
		#240;
	endtask
endmodule

// ==== tb/scfg_regs_props.sv ====
`timescale 1ns/1ps
module scfg_regs_props (
	input wire clk,
	input wire rstn,
	input wire first_output_off_ff,
	input wire chip_sleep_ff,
	input wire leakage_step_double_ff,
	input wire [4:0] pump_bleed_code_ff,
	input wire [9:0] leak_current_ua_ff,
	input wire external_oscillator_select_ff,
	input wire internal_osc_on_ff,
	input wire [2:0] first_output_divide_select_ff,
	input wire [1:0] detector_delay_path_ff,
	input wire down_split_enable_ff,
	input wire first_output_on_ff,
	input wire calib_start_ff
);
	// ****************
	// port relations
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_leak_scaled: assert property (
		leak_current_ua_ff == pump_bleed_code_ff * (leakage_step_double_ff ? 10'h014 : 10'h00a)) else $error("leak wrong");
	a_div_legal: assert property (
		first_output_divide_select_ff != 3'h7) else $error("reserved divider code");
	a_dly_legal: assert property (
		detector_delay_path_ff != 2'h3) else $error("reserved delay mode");
	a_ext_osc_off: assert property (
		external_oscillator_select_ff |-> !internal_osc_on_ff) else $error("both oscillators on");
	a_sleep_all_off: assert property (
		chip_sleep_ff |-> !first_output_on_ff && !internal_osc_on_ff) else $error("awake in sleep");
	a_split_sleep: assert property (
		down_split_enable_ff |-> !chip_sleep_ff) else $error("split in sleep");
	a_out_off: assert property (
		first_output_off_ff |-> !first_output_on_ff) else $error("output on while off");
	a_calib_pulse: assert property (
		calib_start_ff |=> !calib_start_ff) else $error("calibration pulse too long");
	c_calib: cover property (calib_start_ff);
	c_sleep: cover property (chip_sleep_ff);
	c_out_on: cover property (first_output_on_ff);
endmodule

// ==== tb/scfg_regs_tb.sv ====
`timescale 1ns/1ps
module scfg_regs_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cmp_valid = 1'b0;
	logic [7:0] phase_err_ns = 8'h00;
	wire sclk, sdata, latch_en, first_output_off_ff, second_output_off_ff, chip_sleep_ff, leakage_step_double_ff;
	wire [2:0] first_output_divide_select_ff, second_output_divide_select_ff, output_level_code_ff;
	wire [20:0] sigma_numerator_word_ff, fraction_denominator_ff;
	wire [4:0] pump_bleed_code_ff;
	wire [9:0] leak_current_ua_ff;
	wire [1:0] down_split_level_ff, detector_delay_path_ff, ref_path_select_ff, reference_input_type_ff;
	wire [12:0] ref_divider_ff;
	wire pump_bleed_direction_ff, down_split_enable_ff, external_oscillator_select_ff, internal_osc_on_ff;
	wire feedback_divided_ff, detector_polarity_ff, first_output_on_ff, second_output_on_ff;
	wire lock_indicator_ff, calib_start_ff;
	int failures = 0;
	int n_compared = 0;
	int calib_seen = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (calib_start_ff === 1'b1) calib_seen++;
	scfg_host_model u_host (.sclk(sclk), .sdata(sdata), .latch_en(latch_en));
	scfg_regs u_dut (
		.clk(clk), .rstn(rstn), .sclk(sclk), .sdata(sdata), .latch_en(latch_en),
		.cmp_valid(cmp_valid), .phase_err_ns(phase_err_ns),
		.first_output_off_ff(first_output_off_ff), .second_output_off_ff(second_output_off_ff),
		.first_output_divide_select_ff(first_output_divide_select_ff),
		.second_output_divide_select_ff(second_output_divide_select_ff),
		.sigma_numerator_word_ff(sigma_numerator_word_ff), .fraction_denominator_ff(fraction_denominator_ff),
		.chip_sleep_ff(chip_sleep_ff), .leakage_step_double_ff(leakage_step_double_ff),
		.pump_bleed_code_ff(pump_bleed_code_ff), .leak_current_ua_ff(leak_current_ua_ff),
		.pump_bleed_direction_ff(pump_bleed_direction_ff), .down_split_enable_ff(down_split_enable_ff),
		.down_split_level_ff(down_split_level_ff), .detector_delay_path_ff(detector_delay_path_ff),
		.ref_path_select_ff(ref_path_select_ff), .ref_divider_ff(ref_divider_ff),
		.output_level_code_ff(output_level_code_ff),
		.external_oscillator_select_ff(external_oscillator_select_ff), .internal_osc_on_ff(internal_osc_on_ff),
		.feedback_divided_ff(feedback_divided_ff), .detector_polarity_ff(detector_polarity_ff),
		.reference_input_type_ff(reference_input_type_ff), .first_output_on_ff(first_output_on_ff),
		.second_output_on_ff(second_output_on_ff), .lock_indicator_ff(lock_indicator_ff),
		.calib_start_ff(calib_start_ff)
	);
	// ****************
	// tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] addr, input logic [26:0] data);
		u_host.send(1'b0, addr, data, 32);
	endtask
	task automatic cmp(input logic [7:0] err);
		@(negedge clk);
		cmp_valid = 1'b1;
		phase_err_ns = err;
		@(negedge clk);
		cmp_valid = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic finish_test();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#400000;
		failures++;
		$display("MISMATCH %0t timeout", $time);
		finish_test();
	end
	initial begin
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		repeat (5) @(negedge clk);
		chk({first_output_on_ff, internal_osc_on_ff}, 2'b11);
		wr(4'h1, 27'h0dffffe);
		chk({first_output_divide_select_ff, first_output_off_ff, sigma_numerator_word_ff}, {4'hc, 21'h1ffffe});
		wr(4'h2, 27'h1ffffff);
		chk({second_output_divide_select_ff, second_output_off_ff, fraction_denominator_ff}, {4'hf, 21'h1fffff});
		wr(4'h1, 27'h0e00005);
		chk({first_output_divide_select_ff, sigma_numerator_word_ff}, {3'h0, 21'h5});
		wr(4'h2, 27'h0ffffff);
		chk({second_output_divide_select_ff, second_output_off_ff}, 4'he);
		wr(4'h1, 27'h4000abc);
		chk(sigma_numerator_word_ff, 21'h5);
		wr(4'h0, 27'h0100000);
		chk({sigma_numerator_word_ff, calib_seen[3:0]}, {21'habc, 4'h1});
		chk(second_output_divide_select_ff, 3'h0);
		wr(4'h3, 27'h1ffffff);
		chk({leak_current_ua_ff, pump_bleed_direction_ff, down_split_enable_ff, down_split_level_ff}, {10'd620, 4'he});
		chk({leakage_step_double_ff, pump_bleed_code_ff}, 6'h3f);
		chk({detector_delay_path_ff, ref_path_select_ff, ref_divider_ff}, {4'h3, 13'h1fff});
		wr(4'h3, 27'h3ffffff);
		chk({chip_sleep_ff, internal_osc_on_ff, down_split_enable_ff}, 3'b100);
		wr(4'h3, 27'h0000001);
		chk({chip_sleep_ff, internal_osc_on_ff}, 2'b01);
		wr(4'h4, 27'h00847c0);
		chk({external_oscillator_select_ff, internal_osc_on_ff, feedback_divided_ff, detector_polarity_ff,
			reference_input_type_ff}, 6'b101111);
		chk({lock_indicator_ff, first_output_on_ff}, 2'b10);
		repeat (3) cmp(8'd2);
		chk(lock_indicator_ff, 1'b1);
		cmp(8'd2);
		chk({lock_indicator_ff, first_output_on_ff, second_output_on_ff}, 3'b011);
		cmp(8'd3);
		chk({lock_indicator_ff, first_output_on_ff}, 2'b10);
		wr(4'h3, 27'h000a002);
		chk({detector_delay_path_ff, ref_path_select_ff, ref_divider_ff}, {4'h5, 13'h0002});
		wr(4'h3, 27'h0014002);
		chk({detector_delay_path_ff, ref_path_select_ff}, 4'ha);
		wr(4'h3, 27'h0002002);
		chk(ref_path_select_ff, 2'h1);
		wr(4'h4, 27'h0800138);
		chk({ref_path_select_ff, reference_input_type_ff, output_level_code_ff}, 7'h09);
		repeat (4) cmp(8'd16);
		chk(lock_indicator_ff, 1'b1);
		cmp(8'd17);
		chk(lock_indicator_ff, 1'b0);
		u_host.send(1'b1, 4'h1, 27'h0000007, 32);
		u_host.send(1'b0, 4'h1, 27'h0000007, 31);
		chk(sigma_numerator_word_ff, 21'habc);
		finish_test();
	end
endmodule
bind scfg_regs scfg_regs_props u_props (
	.clk(clk), .rstn(rstn), .first_output_off_ff(first_output_off_ff), .chip_sleep_ff(chip_sleep_ff),
	.leakage_step_double_ff(leakage_step_double_ff), .pump_bleed_code_ff(pump_bleed_code_ff),
	.leak_current_ua_ff(leak_current_ua_ff), .external_oscillator_select_ff(external_oscillator_select_ff),
	.internal_osc_on_ff(internal_osc_on_ff), .first_output_divide_select_ff(first_output_divide_select_ff),
	.detector_delay_path_ff(detector_delay_path_ff), .down_split_enable_ff(down_split_enable_ff),
	.first_output_on_ff(first_output_on_ff), .calib_start_ff(calib_start_ff)
);
